// [design/pattern_output_unit.sv]
// pattern output unit: registers, timer trigger selection, output data and pins
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module pattern_output_unit (
    // clock and reset
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    // apb
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [7:0]                        paddr,
    input  wire logic [31:0]                       pwdata,
    output logic [31:0]                            prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    // timer events, one-cycle pulses per channel
    input  wire pattern_output_pkg::timer_event_type timer_events,
    // dma activation per channel
    output logic [3:0]                             dma_req,
    // pattern pins
    output logic [15:0]                            pattern_pin_out,
    output logic [15:0]                            pattern_pin_oe_n
);

    pattern_output_pkg::bus_req_type req;
    logic                            write_stb;
    logic                            mapped;
    logic [31:0]                     read_value;

    logic [15:0] next_data_reg;
    logic [15:0] next_data_enable;
    logic [7:0]  trigger_select_reg;
    logic [3:0]  group_overlap_mode_reg;
    logic [15:0] output_data_reg;
    logic [31:0] port_b_function_reg;

    logic [3:0]  event_a;
    logic [3:0]  event_b;
    logic [15:0] base_data;
    logic [15:0] next_output;
    logic [3:0]  group_fired;

    function automatic logic is_mapped(input logic [7:0] addr);
        if (addr == pattern_output_pkg::OFFSET_NEXT_DATA) begin
            return 1'b1;
        end else if (addr == pattern_output_pkg::OFFSET_NEXT_ENABLE) begin
            return 1'b1;
        end else if (addr == pattern_output_pkg::OFFSET_TRIGGER_SEL) begin
            return 1'b1;
        end else if (addr == pattern_output_pkg::OFFSET_MODE) begin
            return 1'b1;
        end else if (addr == pattern_output_pkg::OFFSET_PORT_OUTPUT) begin
            return 1'b1;
        end else if (addr == pattern_output_pkg::OFFSET_PORT_FUNC) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    function automatic logic hit(input logic stb, input logic [7:0] addr,
                                 input logic [7:0] offset);
        return stb && (addr == offset);
    endfunction

    apb_register_port u_apb (
        .pclk       (pclk),
        .presetn    (presetn),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .mapped     (mapped),
        .read_value (read_value),
        .req        (req),
        .write_stb  (write_stb)
    );

    assign mapped = is_mapped(req.addr);

    // read mux
    always_comb begin
        if (req.addr == pattern_output_pkg::OFFSET_NEXT_DATA) begin
            read_value = {16'h0000, next_data_reg};
        end else if (req.addr == pattern_output_pkg::OFFSET_NEXT_ENABLE) begin
            read_value = {16'h0000, next_data_enable};
        end else if (req.addr == pattern_output_pkg::OFFSET_TRIGGER_SEL) begin
            read_value = {24'h00_0000, trigger_select_reg};
        end else if (req.addr == pattern_output_pkg::OFFSET_MODE) begin
            read_value = {24'h00_0000, pattern_output_pkg::MODE_RESERVED,
                          group_overlap_mode_reg};
        end else if (req.addr == pattern_output_pkg::OFFSET_PORT_OUTPUT) begin
            read_value = {16'h0000, output_data_reg};
        end else if (req.addr == pattern_output_pkg::OFFSET_PORT_FUNC) begin
            read_value = port_b_function_reg;
        end else begin
            read_value = 32'h0000_0000;
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            next_data_enable       <= pattern_output_pkg::RESET_NEXT_ENABLE;
            trigger_select_reg     <= pattern_output_pkg::RESET_TRIGGER_SEL;
            group_overlap_mode_reg <= pattern_output_pkg::RESET_MODE;
            port_b_function_reg    <= pattern_output_pkg::RESET_PORT_FUNC;
        end else if (write_stb) begin
            if (req.addr == pattern_output_pkg::OFFSET_NEXT_ENABLE) begin
                next_data_enable <= req.wdata[15:0];
            end else if (req.addr == pattern_output_pkg::OFFSET_TRIGGER_SEL) begin
                trigger_select_reg <= req.wdata[7:0];
            end else if (req.addr == pattern_output_pkg::OFFSET_MODE) begin
                group_overlap_mode_reg <= req.wdata[3:0];
            end else if (req.addr == pattern_output_pkg::OFFSET_PORT_FUNC) begin
                port_b_function_reg <= req.wdata;
            end
        end
    end

    // next data, refilled by software or dma
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            next_data_reg <= pattern_output_pkg::RESET_NEXT_DATA;
        end else if (hit(write_stb, req.addr, pattern_output_pkg::OFFSET_NEXT_DATA)) begin
            next_data_reg <= req.wdata[15:0];
        end
    end

    // capture replaces match A on channels in capture mode
    assign event_a = (timer_events.match_a & ~timer_events.capture_mode)
                   | (timer_events.capture_a & timer_events.capture_mode);
    assign event_b = timer_events.match_b;

    // software write first, trigger transfer on top
    assign base_data = hit(write_stb, req.addr, pattern_output_pkg::OFFSET_PORT_OUTPUT)
                     ? req.wdata[15:0] : output_data_reg;

    genvar g;
    generate
        for (g = 0; g < pattern_output_pkg::NUM_GROUPS; g++) begin : gen_group
            group_transfer u_group (
                .trigger_sel (trigger_select_reg[2*g +: 2]),
                .mode        (pattern_output_pkg::group_mode_type'(group_overlap_mode_reg[g])),
                .event_a     (event_a),
                .event_b     (event_b),
                .next_bits   (next_data_reg[4*g +: 4]),
                .enable_bits (next_data_enable[4*g +: 4]),
                .current     (base_data[4*g +: 4]),
                .result      (next_output[4*g +: 4]),
                .fired       (group_fired[g])
            );
        end
    endgenerate

    // output data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_data_reg <= pattern_output_pkg::RESET_PORT_OUTPUT;
        end else begin
            output_data_reg <= next_output;
        end
    end

    // dma activation on the effective match A
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_req <= 4'h0;
        end else begin
            dma_req <= event_a;
        end
    end

    // pins
    assign pattern_pin_out = output_data_reg;
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            pattern_pin_oe_n[i] = (port_b_function_reg[2*i +: 2]
                                   != pattern_output_pkg::PIN_FUNC_PATTERN);
        end
    end

    // checks
    logic port_write;
    logic g0_a;
    logic g0_b;
    logic g1_a;
    logic g1_b;
    logic g3_a;
    logic any_event;
    assign port_write = hit(write_stb, req.addr, pattern_output_pkg::OFFSET_PORT_OUTPUT);
    assign g0_a = event_a[trigger_select_reg[1:0]];
    assign g0_b = event_b[trigger_select_reg[1:0]];
    assign g1_a = event_a[trigger_select_reg[3:2]];
    assign g1_b = event_b[trigger_select_reg[3:2]];
    assign g3_a = event_a[trigger_select_reg[7:6]];
    assign any_event = (event_a != 4'h0) || (event_b != 4'h0);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_g0_nov_a;
        group_overlap_mode_reg[0] && g0_a && !port_write;
    endsequence

    sequence seq_g0_nov_b_only;
        group_overlap_mode_reg[0] && g0_b && !g0_a && !port_write;
    endsequence

    sequence seq_g1_ord_a;
        !group_overlap_mode_reg[1] && g1_a && !port_write;
    endsequence

    sequence seq_g3_nov_a;
        group_overlap_mode_reg[3] && g3_a && !port_write;
    endsequence

    sequence seq_port_write_only;
        port_write && !any_event;
    endsequence

    chk_nov_a_copy: assert property (seq_g0_nov_a |=>
        ((output_data_reg[3:0] ^ $past(next_data_reg[3:0])) & $past(next_data_enable[3:0]))
        == 4'h0)
        else $error("match A did not copy enabled bits");

    chk_nov_b_zeros: assert property (seq_g0_nov_b_only |=>
        (output_data_reg[3:0] & $past(next_data_enable[3:0] & ~next_data_reg[3:0])) == 4'h0
        && ((output_data_reg[3:0] ^ $past(output_data_reg[3:0])) & $past(next_data_reg[3:0]))
        == 4'h0)
        else $error("match B copy wrong");

    chk_b_no_rise: assert property (seq_g0_nov_b_only |=>
        (output_data_reg[3:0] & ~$past(output_data_reg[3:0])) == 4'h0)
        else $error("output rose on match B");

    chk_ordinary_ignore_b: assert property (
        !group_overlap_mode_reg[1] && g1_b && !g1_a && !port_write
        |=> $stable(output_data_reg[7:4]))
        else $error("ordinary group moved on match B");

    chk_capture_gates: assert property (
        timer_events.capture_mode[trigger_select_reg[1:0]]
        && timer_events.match_a[trigger_select_reg[1:0]]
        && !timer_events.capture_a[trigger_select_reg[1:0]] && !g0_b && !port_write
        |=> $stable(output_data_reg[3:0]))
        else $error("match A used while in capture mode");

    chk_pin_function: assert property (
        hit(write_stb, req.addr, pattern_output_pkg::OFFSET_PORT_FUNC)
        ##1 !write_stb |=> pattern_pin_oe_n[0] == ($past(req.wdata[1:0], 2) != 2'b11)
        && pattern_pin_out == output_data_reg)
        else $error("pin enable does not follow function field");

    chk_dma_request: assert property (event_a != 4'h0 |=> dma_req == $past(event_a))
        else $error("dma request missing");

    chk_disabled_hold: assert property (
        (g0_a || g0_b) && next_data_enable[3:0] == 4'h0 && !port_write
        |=> $stable(output_data_reg[3:0]))
        else $error("disabled bits changed");

    chk_select_reset: assert property ($rose(presetn) |->
        trigger_select_reg == pattern_output_pkg::RESET_TRIGGER_SEL)
        else $error("trigger select not at reset value");

    chk_ordinary_a_copy: assert property (seq_g1_ord_a |=>
        ((output_data_reg[7:4] ^ $past(next_data_reg[7:4]))
         & $past(next_data_enable[7:4])) == 4'h0
        && ((output_data_reg[7:4] ^ $past(output_data_reg[7:4]))
            & ~$past(next_data_enable[7:4])) == 4'h0)
        else $error("ordinary group copy wrong");

    chk_group3_copy: assert property (seq_g3_nov_a |=>
        ((output_data_reg[15:12] ^ $past(next_data_reg[15:12]))
         & $past(next_data_enable[15:12])) == 4'h0)
        else $error("group 3 match A did not copy");

    chk_capture_copy: assert property (
        timer_events.capture_mode[trigger_select_reg[1:0]]
        && timer_events.capture_a[trigger_select_reg[1:0]] && !port_write
        |=> ((output_data_reg[3:0] ^ $past(next_data_reg[3:0]))
             & $past(next_data_enable[3:0])) == 4'h0)
        else $error("input capture did not copy");

    chk_idle_hold: assert property (!any_event && !port_write |=>
        $stable(output_data_reg))
        else $error("output moved without trigger");

    chk_port_write: assert property (seq_port_write_only |=>
        output_data_reg == $past(req.wdata[15:0]))
        else $error("port write did not land");

    chk_dma_quiet: assert property (event_a == 4'h0 |=> dma_req == 4'h0)
        else $error("dma request without match");

    chk_pin15_function: assert property (
        hit(write_stb, req.addr, pattern_output_pkg::OFFSET_PORT_FUNC)
        |=> pattern_pin_oe_n[15]
        == ($past(req.wdata[31:30]) != pattern_output_pkg::PIN_FUNC_PATTERN))
        else $error("pin 15 enable does not follow function field");

endmodule // pattern_output_unit
`default_nettype wire

// [design/pattern_output_pkg.sv]
// shared constants and types of the pattern output unit
// Functional notes
// - non-overlap group: match A copies every enabled next-data bit into output
// - non-overlap group: match B copies only enabled next-data bits that are 0
// - non-overlap: outputs fall at match B, rise later at match A
// - non-overlap mode is chosen separately for each 4-bit group
// - channel in capture mode triggers on its input capture instead of match A
// - a pin drives the pattern only when its function field is 11
// - each channel's effective match A also raises its DMA request for refilling, whether or not a group selects it
// - bits with enable 0 never copy and keep their output
// - 2-bit trigger select per group picks channel 0..3; reset selects channel 3
// - ordinary group updates only on match A of its channel
package pattern_output_pkg;

    localparam int NUM_GROUPS   = 4;
    localparam int NUM_CHANNELS = 4;
    localparam int DATA_WIDTH   = 16;

    localparam logic [7:0] OFFSET_NEXT_DATA   = 8'h00;
    localparam logic [7:0] OFFSET_NEXT_ENABLE = 8'h04;
    localparam logic [7:0] OFFSET_TRIGGER_SEL = 8'h08;
    localparam logic [7:0] OFFSET_MODE        = 8'h0c;
    localparam logic [7:0] OFFSET_PORT_OUTPUT = 8'h10;
    localparam logic [7:0] OFFSET_PORT_FUNC   = 8'h14;

    localparam logic [15:0] RESET_NEXT_DATA   = 16'h0000;
    localparam logic [15:0] RESET_NEXT_ENABLE = 16'h0000;
    localparam logic [7:0]  RESET_TRIGGER_SEL = 8'hff;
    localparam logic [3:0]  RESET_MODE        = 4'h0;
    localparam logic [3:0]  MODE_RESERVED     = 4'hf;
    localparam logic [15:0] RESET_PORT_OUTPUT = 16'h0000;
    localparam logic [31:0] RESET_PORT_FUNC   = 32'h0000_0000;

    localparam logic [1:0]  PIN_FUNC_PATTERN  = 2'b11;

    typedef enum logic [0:0] {
        MODE_ORDINARY   = 1'b0,
        MODE_NONOVERLAP = 1'b1
    } group_mode_type;

    typedef struct packed {
        logic [7:0]  addr;
        logic        write;
        logic [31:0] wdata;
    } bus_req_type;

    typedef struct packed {
        logic [3:0] match_a;
        logic [3:0] match_b;
        logic [3:0] capture_a;
        logic [3:0] capture_mode;
    } timer_event_type;

endpackage

// [design/apb_register_port.sv]
// apb slave front end: strobes, registered read data, error on unmapped
`timescale 1ns/100ps
`default_nettype none
module apb_register_port (
    // clock and reset
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    // apb
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [7:0]                        paddr,
    input  wire logic [31:0]                       pwdata,
    output logic [31:0]                            prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    // register side
    input  wire logic                              mapped,
    input  wire logic [31:0]                       read_value,
    output pattern_output_pkg::bus_req_type        req,
    output logic                                   write_stb
);

    assign req = {paddr, pwrite, pwdata};

    // zero-wait access phase
    assign pready    = psel & penable;
    assign pslverr   = psel & penable & ~mapped;
    assign write_stb = psel & penable & pwrite & mapped;

    // read data captured in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= mapped ? read_value : 32'h0000_0000;
        end
    end

endmodule // apb_register_port
`default_nettype wire

// [design/group_transfer.sv]
// next-data to output transfer for one 4-bit group
`timescale 1ns/100ps
`default_nettype none
module group_transfer (
    // configuration
    input  wire logic [1:0]                        trigger_sel,
    input  wire pattern_output_pkg::group_mode_type mode,
    // timer events per channel
    input  wire logic [3:0]                        event_a,
    input  wire logic [3:0]                        event_b,
    // data
    input  wire logic [3:0]                        next_bits,
    input  wire logic [3:0]                        enable_bits,
    input  wire logic [3:0]                        current,
    output logic [3:0]                             result,
    output logic                                   fired
);

    logic fire_a;
    logic fire_b;

    assign fire_a = event_a[trigger_sel];
    assign fire_b = event_b[trigger_sel] && (mode == pattern_output_pkg::MODE_NONOVERLAP);
    assign fired  = fire_a | fire_b;

    always_comb begin
        result = current;
        if (fire_a) begin
            // all enabled bits, any value
            result = (next_bits & enable_bits) | (current & ~enable_bits);
        end else if (fire_b) begin
            // only enabled zeros: outputs may fall, never rise
            result = current & ~(enable_bits & ~next_bits);
        end
    end

endmodule // group_transfer
`default_nettype wire

// [tb/pattern_load_model.sv]
// external load model on the pattern pins
`timescale 1ns/100ps
`default_nettype none
module pattern_load_model (
    // clock
    input  wire logic        pclk,
    // pattern pins
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] pin_oe_n,
    // level seen by the loads
    output logic      [15:0] pin_level
);
    logic [15:0] last_level = 16'h0000;

    // undriven pins float away from their last level every cycle
    always_comb begin
        pin_level = (~pin_oe_n & pin_out) | (pin_oe_n & ~last_level);
    end

    always_ff @(posedge pclk) begin
        last_level <= pin_level;
    end
endmodule // pattern_load_model
`default_nettype wire

// [tb/pattern_output_unit_bench.sv]
// self-checking bench of the pattern output unit
`timescale 1ns/100ps
`default_nettype none
module pattern_output_unit_bench;
    typedef struct packed {
        logic [7:0]                           sel;
        logic [3:0]                           mode;
        logic [15:0]                          en;
        logic [15:0]                          nxt;
        logic [15:0]                          port;
        pattern_output_pkg::timer_event_type  ev;
        logic [15:0]                          exp_pins;
        logic [3:0]                           exp_dma;
    } row_type;

    logic                                 pclk         = 1'b0;
    logic                                 presetn      = 1'b0;
    logic                                 psel         = 1'b0;
    logic                                 penable      = 1'b0;
    logic                                 pwrite       = 1'b0;
    logic [7:0]                           paddr        = 8'h00;
    logic [31:0]                          pwdata       = 32'h0000_0000;
    pattern_output_pkg::timer_event_type  timer_events = '0;
    logic [31:0]                          prdata;
    logic                                 pready;
    logic                                 pslverr;
    logic [3:0]                           dma_req;
    logic [15:0]                          pattern_pin_out;
    logic [15:0]                          pattern_pin_oe_n;
    logic [15:0]                          pin_level;
    int                                   bad_count    = 0;
    int                                   compares     = 0;
    int                                   cycles       = 0;
    logic [7:0]                           reg_addr [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    logic [31:0]                          reg_init [6] = '{32'h0000_0000, 32'h0000_0000,
                                                           32'h0000_00ff, 32'h0000_00f0,
                                                           32'h0000_0000, 32'h0000_0000};
    row_type rows [11] = '{
        '{8'hff, 4'h0, 16'hffff, 16'ha5c3, 16'h0000, 16'h8000, 16'ha5c3, 4'h8},
        '{8'h00, 4'h0, 16'h00ff, 16'hffff, 16'h1234, 16'h1000, 16'h12ff, 4'h1},
        '{8'h55, 4'h0, 16'hffff, 16'h0f0f, 16'h3c3c, 16'h0200, 16'h3c3c, 4'h0},
        '{8'haa, 4'hf, 16'hffff, 16'h0f0f, 16'h3c3c, 16'h0400, 16'h0c0c, 4'h0},
        '{8'haa, 4'hf, 16'hffff, 16'h0f0f, 16'h3c3c, 16'h4000, 16'h0f0f, 4'h4},
        '{8'h00, 4'hc, 16'hffff, 16'h0000, 16'hffff, 16'h0100, 16'h00ff, 4'h0},
        '{8'hff, 4'h0, 16'hffff, 16'h5a5a, 16'h0000, 16'h0088, 16'h5a5a, 4'h8},
        '{8'hff, 4'h0, 16'hffff, 16'h5a5a, 16'h0000, 16'h8008, 16'h0000, 4'h0},
        '{8'he4, 4'h0, 16'hffff, 16'hffff, 16'h0000, 16'h2000, 16'h00f0, 4'h2},
        '{8'h00, 4'h0, 16'hfff0, 16'hffff, 16'h0000, 16'h1000, 16'hfff0, 4'h1},
        '{8'h00, 4'hf, 16'hffff, 16'h0f0f, 16'h3c3c, 16'h1100, 16'h0f0f, 4'h1}
    };

    pattern_output_unit u_pattern_output_unit (
        .pclk             (pclk),
        .presetn          (presetn),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .paddr            (paddr),
        .pwdata           (pwdata),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .timer_events     (timer_events),
        .dma_req          (dma_req),
        .pattern_pin_out  (pattern_pin_out),
        .pattern_pin_oe_n (pattern_pin_oe_n)
    );

    pattern_load_model u_pattern_load_model (
        .pclk      (pclk),
        .pin_out   (pattern_pin_out),
        .pin_oe_n  (pattern_pin_oe_n),
        .pin_level (pin_level)
    );

    always #20 pclk = ~pclk;

    task automatic results;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        cmp(r, exp);
        cmp({31'h0000_0000, e}, {31'h0000_0000, exp_err});
    endtask

    task automatic run_row(input row_type r);
        wr(pattern_output_pkg::OFFSET_PORT_OUTPUT, {16'h0000, r.port});
        wr(pattern_output_pkg::OFFSET_NEXT_ENABLE, {16'h0000, r.en});
        wr(pattern_output_pkg::OFFSET_TRIGGER_SEL, {24'h00_0000, r.sel});
        wr(pattern_output_pkg::OFFSET_MODE, {24'h00_0000, 4'hf, r.mode});
        wr(pattern_output_pkg::OFFSET_NEXT_DATA, {16'h0000, r.nxt});
        @(posedge pclk);
        timer_events <= r.ev;
        @(posedge pclk);
        timer_events <= '0;
        #1;
        cmp({16'h0000, pattern_pin_out}, {16'h0000, r.exp_pins});
        cmp({28'h000_0000, dma_req}, {28'h000_0000, r.exp_dma});
        @(posedge pclk);
        #1;
        cmp({28'h000_0000, dma_req}, 32'h0000_0000);
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            results();
        end
    end

    initial begin
        logic [31:0] r;
        logic        e;
        repeat (10) @(posedge pclk);
        cmp({16'h0000, pattern_pin_oe_n}, 32'h0000_ffff);
        presetn <= 1'b1;
        foreach (rows[i]) run_row(rows[i]);
        wr(pattern_output_pkg::OFFSET_PORT_FUNC, 32'hc000_000b);
        #1;
        cmp({16'h0000, pattern_pin_oe_n}, 32'h0000_7ffe);
        cmp({30'h0000_0000, pin_level[15], pin_level[0]}, 32'h0000_0001);
        apb(1'b1, 8'h18, 32'hffff_ffff, r, e);
        cmp({31'h0000_0000, e}, 32'h0000_0001);
        rd_chk(8'h18, 32'h0000_0000, 1'b1);
        wr(pattern_output_pkg::OFFSET_MODE, 32'h0000_0005);
        rd_chk(pattern_output_pkg::OFFSET_MODE, 32'h0000_00f5, 1'b0);
        wr(pattern_output_pkg::OFFSET_TRIGGER_SEL, 32'h0000_0036);
        rd_chk(pattern_output_pkg::OFFSET_TRIGGER_SEL, 32'h0000_0036, 1'b0);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        #1;
        cmp({16'h0000, pattern_pin_out}, 32'h0000_0000);
        cmp({16'h0000, pattern_pin_oe_n}, 32'h0000_ffff);
        @(posedge pclk);
        presetn <= 1'b1;
        foreach (reg_addr[i]) rd_chk(reg_addr[i], reg_init[i], 1'b0);
        results();
    end
endmodule // pattern_output_unit_bench
`default_nettype wire
